// *** sampling_trigger_filter.sv ***
// sampling control: filtered triggers, channel scan, sample buffer, apb regs
`timescale 1ns/10ps
`default_nettype none
module sampling_trigger_filter #(
	parameter int FILT_CYCLES = stf_pkg::FILTER_CYCLES,
	parameter int ADDR_W = stf_pkg::BUF_ADDR_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_paddr,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_ext_clk,
	input wire logic i_ext_start,
	input wire logic i_ext_stop,
	input wire logic i_jmp_diff,
	input wire logic i_jmp_current,
	output logic o_hold,
	output logic o_adc_start,
	output logic [3:0] o_chan,
	output logic [1:0] o_range,
	input wire logic i_adc_valid,
	input wire logic [11:0] i_adc_data,
	output logic o_irq
);
	typedef struct packed {
		stf_pkg::acq_state_t st;
		logic busy;
		logic [3:0] chan;
		logic hold;
		logic adcs;
		logic [ADDR_W-1:0] wptr;
		logic [ADDR_W-1:0] rptr;
		logic [ADDR_W:0] lvl;
		logic [31:0] cnt;
		logic [1:0] ssrc;
		logic [1:0] psrc;
		logic ring;
		logic below;
		logic [1:0] rng;
		logic [11:0] cmp;
		logic [31:0] stop_n;
		logic [3:0] ist;
		logic [3:0] ien;
		logic ack;
		logic [31:0] prdata;
		logic err;
		logic [1:0] j0;
		logic [1:0] j1;
		logic [1:0] j2;
		logic [1:0] jl;
	} regs_t;

	localparam logic [ADDR_W:0] FULL_LVL = (ADDR_W+1)'(1) << ADDR_W;

	regs_t q_r;
	regs_t q_nxt;
	logic [11:0] mem [0:(1<<ADDR_W)-1];
	logic [11:0] mem_q;
	logic wr_mem;
	logic acc;
	logic wr_go;
	logic rd_go;
	logic scan_ok;
	logic [3:0] last_ch;
	logic [2:0] pins;

	// compare condition of a sample against the threshold
	function automatic logic cmp_hit(input logic [11:0] s, input logic [11:0] t,
		input logic below);
		cmp_hit = below ? (s < t) : (s >= t);
	endfunction

	// ----------------------------------------------------------------
	// input filters
	// ----------------------------------------------------------------
	assign pins = {i_ext_stop, i_ext_start, i_ext_clk};
	filt_if fl[3]();
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_filt
			glitch_filter #(
				.PER(FILT_CYCLES),
				.CNT_W(stf_pkg::FILT_CNT_W)
			) u_filt (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_pin(pins[g]),
				.o_f(fl[g])
			);
		end
	endgenerate

	// bus phase decode
	assign acc = i_psel & i_penable;
	assign wr_go = acc & q_r.ack & i_pwrite;
	assign rd_go = acc & q_r.ack & ~i_pwrite;
	assign last_ch = q_r.jl[0] ? stf_pkg::LAST_CH_DIFF : stf_pkg::LAST_CH_SE;
	assign scan_ok = (q_r.st == stf_pkg::ST_RUN) ||
		(q_r.st == stf_pkg::ST_ARMED && q_r.ssrc == stf_pkg::START_CMP);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic store;
		logic push;
		logic pop;
		logic ovw;
		logic hit;
		logic [3:0] ev;
		store = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		ovw = 1'b0;
		hit = 1'b0;
		ev = '0;
		wr_mem = 1'b0;
		q_nxt = q_r;
		q_nxt.hold = 1'b0;
		q_nxt.adcs = 1'b0;
		q_nxt.ack = 1'b0;
		// jumper synchroniser, taken when stages two and three agree
		q_nxt.j0 = {i_jmp_current, i_jmp_diff};
		q_nxt.j1 = q_r.j0;
		q_nxt.j2 = q_r.j1;
		if (q_r.j1 == q_r.j2) begin
			q_nxt.jl = q_r.j2;
		end
		// access phase, first cycle: latch answer
		if (acc && !q_r.ack) begin
			q_nxt.ack = 1'b1;
			q_nxt.err = 1'b0;
			unique case (i_paddr)
				stf_pkg::OFF_CTRL: q_nxt.prdata = {24'h0, q_r.rng, q_r.below, q_r.ring,
					q_r.psrc, q_r.ssrc};
				stf_pkg::OFF_CMD: q_nxt.prdata = 32'h0;
				stf_pkg::OFF_STOP_CNT: q_nxt.prdata = q_r.stop_n;
				stf_pkg::OFF_CMP: q_nxt.prdata = {20'h0, q_r.cmp};
				stf_pkg::OFF_STATUS: q_nxt.prdata = {22'h0, fl[2].level, fl[1].level,
					fl[0].level, q_r.jl, (q_r.lvl == FULL_LVL), (q_r.lvl == '0), q_r.st};
				stf_pkg::OFF_LEVEL: q_nxt.prdata = 32'(q_r.lvl);
				stf_pkg::OFF_DATA: q_nxt.prdata = (q_r.lvl == '0) ? 32'h0 : {20'h0, mem_q};
				stf_pkg::OFF_INT_STAT: q_nxt.prdata = {28'h0, q_r.ist};
				stf_pkg::OFF_INT_EN: q_nxt.prdata = {28'h0, q_r.ien};
				stf_pkg::OFF_INT_CLR: q_nxt.prdata = 32'h0;
				stf_pkg::OFF_COUNT: q_nxt.prdata = q_r.cnt;
				default: begin
					q_nxt.prdata = 32'h0;
					q_nxt.err = 1'b1;
				end
			endcase
		end
		// register writes at the completing edge
		if (wr_go) begin
			unique case (i_paddr)
				stf_pkg::OFF_CTRL: begin
					q_nxt.ssrc = i_pwdata[stf_pkg::CTRL_START_LSB +: 2];
					q_nxt.psrc = i_pwdata[stf_pkg::CTRL_STOP_LSB +: 2];
					q_nxt.ring = i_pwdata[stf_pkg::CTRL_RING];
					q_nxt.below = i_pwdata[stf_pkg::CTRL_BELOW];
					q_nxt.rng = i_pwdata[stf_pkg::CTRL_RANGE_LSB +: 2];
				end
				stf_pkg::OFF_CMD: begin
					if (i_pwdata[stf_pkg::CMD_ARM] && q_r.st == stf_pkg::ST_IDLE) begin
						q_nxt.st = stf_pkg::ST_ARMED;
						q_nxt.cnt = '0;
					end
					if (i_pwdata[stf_pkg::CMD_START] && q_r.st == stf_pkg::ST_ARMED &&
						q_r.ssrc == stf_pkg::START_SW) begin
						q_nxt.st = stf_pkg::ST_RUN;
						ev[stf_pkg::EV_START] = 1'b1;
					end
					if (i_pwdata[stf_pkg::CMD_STOP] && q_r.st != stf_pkg::ST_IDLE) begin
						q_nxt.st = stf_pkg::ST_IDLE;
						ev[stf_pkg::EV_STOP] = 1'b1;
					end
					if (i_pwdata[stf_pkg::CMD_FLUSH]) begin
						q_nxt.wptr = '0;
						q_nxt.rptr = '0;
						q_nxt.lvl = '0;
					end
				end
				stf_pkg::OFF_STOP_CNT: q_nxt.stop_n = i_pwdata;
				stf_pkg::OFF_CMP: q_nxt.cmp = i_pwdata[11:0];
				stf_pkg::OFF_INT_EN: q_nxt.ien = i_pwdata[3:0];
				stf_pkg::OFF_INT_CLR: q_nxt.ist = q_r.ist & ~i_pwdata[3:0];
				default: ;
			endcase
		end
		// reading the data register pops one word
		if (rd_go && i_paddr == stf_pkg::OFF_DATA && q_r.lvl != '0) begin
			pop = 1'b1;
		end
		// external start edge while armed
		if (fl[1].rise && q_nxt.st == stf_pkg::ST_ARMED &&
			q_r.ssrc == stf_pkg::START_EXT) begin
			q_nxt.st = stf_pkg::ST_RUN;
			ev[stf_pkg::EV_START] = 1'b1;
		end
		// external stop edge while running
		if (fl[2].rise && q_r.st == stf_pkg::ST_RUN && q_r.psrc == stf_pkg::STOP_EXT) begin
			q_nxt.st = stf_pkg::ST_IDLE;
			ev[stf_pkg::EV_STOP] = 1'b1;
		end
		// filtered sampling clock edge opens a scan
		if (fl[0].rise && scan_ok && !q_r.busy) begin
			q_nxt.hold = 1'b1;
			q_nxt.adcs = 1'b1;
			q_nxt.chan = 4'h0;
			q_nxt.busy = 1'b1;
		end
		// conversion result: store and advance the scan
		if (i_adc_valid && q_r.busy) begin
			hit = cmp_hit(i_adc_data, q_r.cmp, q_r.below);
			if (q_r.st == stf_pkg::ST_RUN) begin
				store = 1'b1;
			end else if (q_r.st == stf_pkg::ST_ARMED && q_r.ssrc == stf_pkg::START_CMP && hit) begin
				store = 1'b1;
				q_nxt.st = stf_pkg::ST_RUN;
				ev[stf_pkg::EV_START] = 1'b1;
			end
			if (q_r.chan >= last_ch) begin
				q_nxt.busy = 1'b0;
				q_nxt.chan = 4'h0; // idle channel stays inside either scan range
			end else begin
				q_nxt.chan = q_r.chan + 4'h1;
				q_nxt.adcs = 1'b1;
			end
		end
		if (store) begin
			if (q_r.lvl == FULL_LVL && !q_r.ring) begin
				ev[stf_pkg::EV_OVERRUN] = 1'b1;
			end else begin
				wr_mem = 1'b1;
				push = 1'b1;
				ovw = (q_r.lvl == FULL_LVL);
				q_nxt.wptr = q_r.wptr + 1'b1;
				q_nxt.cnt = q_r.cnt + 32'h1;
				ev[stf_pkg::EV_STORED] = 1'b1;
				if ((q_r.psrc == stf_pkg::STOP_COUNT && q_r.cnt + 32'h1 >= q_r.stop_n) ||
					(q_r.psrc == stf_pkg::STOP_CMP && q_r.st == stf_pkg::ST_RUN && hit)) begin
					q_nxt.st = stf_pkg::ST_IDLE;
					ev[stf_pkg::EV_STOP] = 1'b1;
				end
			end
		end
		// pointers and level; ring overwrite drops the oldest word
		if (pop || ovw) begin
			q_nxt.rptr = q_r.rptr + ADDR_W'(pop) + ADDR_W'(ovw);
		end
		if (!(wr_go && i_paddr == stf_pkg::OFF_CMD && i_pwdata[stf_pkg::CMD_FLUSH])) begin
			q_nxt.lvl = q_r.lvl + (ADDR_W+1)'(push) - (ADDR_W+1)'(pop) - (ADDR_W+1)'(ovw);
		end
		// sticky events, set wins over clear
		q_nxt.ist = q_nxt.ist | ev;
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q_r <= '0;
			q_r.st <= stf_pkg::ST_IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	// sample buffer with registered read of the next head word
	always_ff @(posedge i_clk) begin
		if (wr_mem) begin
			mem[q_r.wptr] <= i_adc_data;
		end
		mem_q <= mem[q_nxt.rptr];
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_prdata = q_r.prdata;
	assign o_pready = q_r.ack;
	assign o_pslverr = q_r.ack & q_r.err;
	assign o_hold = q_r.hold;
	assign o_adc_start = q_r.adcs;
	assign o_chan = q_r.chan;
	assign o_range = q_r.rng;
	assign o_irq = |(q_r.ist & q_r.ien);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	hold_after_edge_a: assert property ((fl[0].rise && scan_ok && !q_r.busy) |=> o_hold)
		else $error("no hold after sampling clock edge");
	first_start_a: assert property (o_hold |-> o_adc_start && o_chan == 4'h0 ##1 !o_hold)
		else $error("first start pulse not with hold");
	no_hold_idle_a: assert property ((q_r.st == stf_pkg::ST_IDLE && !q_r.busy) |=> !o_hold)
		else $error("hold without armed acquisition");
	sw_start_a: assert property ((wr_go && i_paddr == stf_pkg::OFF_CMD &&
		i_pwdata[stf_pkg::CMD_START] && !i_pwdata[stf_pkg::CMD_STOP] &&
		q_r.st == stf_pkg::ST_ARMED && q_r.ssrc == stf_pkg::START_SW) |=>
		q_r.st == stf_pkg::ST_RUN && q_r.ist[stf_pkg::EV_START])
		else $error("software start ignored");
	ext_stop_a: assert property ((fl[2].rise && q_r.st == stf_pkg::ST_RUN &&
		q_r.psrc == stf_pkg::STOP_EXT) |=> q_r.st == stf_pkg::ST_IDLE)
		else $error("external stop ignored");
	fifo_full_hold_a: assert property ((q_r.lvl == FULL_LVL && !q_r.ring && !wr_go) |->
		!wr_mem)
		else $error("fifo overwrote when full");
	chan_bound_a: assert property (o_chan <= last_ch || $past(q_r.jl) != q_r.jl)
		else $error("channel beyond scan limit");
	range_follow_a: assert property ((wr_go && i_paddr == stf_pkg::OFF_CTRL) |=>
		o_range == $past(i_pwdata[stf_pkg::CTRL_RANGE_LSB +: 2]))
		else $error("range setting not applied");
	irq_mask_a: assert property ((q_r.ien == 4'h0) |-> !o_irq)
		else $error("interrupt while disabled");

	cover_run_c: cover property (q_r.st == stf_pkg::ST_RUN ##[1:100] q_r.st == stf_pkg::ST_IDLE);
	cover_ring_c: cover property (q_r.ring && q_r.lvl == FULL_LVL && wr_mem);
	cover_irq_c: cover property ($rose(o_irq));
endmodule
`default_nettype wire

// *** stf_pkg.sv ***
// shared constants and types of the sampling trigger and filter block
package stf_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int FILTER_TIME_MS = 1;
	localparam int FILTER_CYCLES = CLK_HZ / 1000 * FILTER_TIME_MS;
	localparam int COUPLER_TIME_MS = 1;
	localparam int CTRL_DELAY_MS = COUPLER_TIME_MS + FILTER_TIME_MS;
	localparam int FILT_CNT_W = 16;
	localparam int BUF_ADDR_W = 18;
	localparam int SMP_W = 12;
	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_CH_SE = 4'hf;
	localparam logic [3:0] LAST_CH_DIFF = 4'h7;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STOP_CNT = 8'h08;
	localparam logic [7:0] OFF_CMP = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_LEVEL = 8'h14;
	localparam logic [7:0] OFF_DATA = 8'h18;
	localparam logic [7:0] OFF_INT_STAT = 8'h1c;
	localparam logic [7:0] OFF_INT_EN = 8'h20;
	localparam logic [7:0] OFF_INT_CLR = 8'h24;
	localparam logic [7:0] OFF_COUNT = 8'h28;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_LSB = 0;
	localparam int CTRL_STOP_LSB = 2;
	localparam int CTRL_RING = 4;
	localparam int CTRL_BELOW = 5;
	localparam int CTRL_RANGE_LSB = 6;
	localparam int CMD_ARM = 0;
	localparam int CMD_START = 1;
	localparam int CMD_STOP = 2;
	localparam int CMD_FLUSH = 3;
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_OVERRUN = 2;
	localparam int EV_STORED = 3;
	// ----------------------------------------------------------------
	// trigger sources
	// ----------------------------------------------------------------
	localparam logic [1:0] START_SW = 2'h0;
	localparam logic [1:0] START_CMP = 2'h1;
	localparam logic [1:0] START_EXT = 2'h2;
	localparam logic [1:0] STOP_COUNT = 2'h0;
	localparam logic [1:0] STOP_CMP = 2'h1;
	localparam logic [1:0] STOP_EXT = 2'h2;
	localparam logic [1:0] STOP_SW = 2'h3;
	// ----------------------------------------------------------------
	// acquisition states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ARMED = 3'h2,
		ST_RUN = 3'h4
	} acq_state_t;
endpackage

// *** filt_if.sv ***
// filtered control level and its edge pulses
`timescale 1ns/10ps
`default_nettype none
interface filt_if;
	logic level;
	logic rise;
	logic fall;
	modport src(output level, output rise, output fall);
	modport dst(input level, input rise, input fall);
endinterface
`default_nettype wire

// *** glitch_filter.sv ***
// three-stage synchroniser and persistence filter for one control pin
`timescale 1ns/10ps
`default_nettype none
module glitch_filter #(
	parameter int PER = stf_pkg::FILTER_CYCLES,
	parameter int CNT_W = stf_pkg::FILT_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	filt_if.src o_f
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic [CNT_W-1:0] cnt;
		logic rise;
		logic fall;
	} filt_state_t;

	filt_state_t q_r;
	filt_state_t q_nxt;

	// ----------------------------------------------------------------
	// filter
	// ----------------------------------------------------------------
	// restart unless a stable synced level differs from the accepted one
	always_comb begin
		q_nxt = q_r;
		q_nxt.s1 = i_pin;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		q_nxt.rise = 1'b0;
		q_nxt.fall = 1'b0;
		if (q_r.s2 != q_r.s3 || q_r.s3 == q_r.level) begin
			q_nxt.cnt = '0;
		end else if (q_r.cnt == CNT_W'(PER - 1)) begin
			q_nxt.level = q_r.s3;
			q_nxt.rise = q_r.s3;
			q_nxt.fall = ~q_r.s3;
			q_nxt.cnt = '0;
		end else begin
			q_nxt.cnt = q_r.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_f.level = q_r.level;
	assign o_f.rise = q_r.rise;
	assign o_f.fall = q_r.fall;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	level_needs_period_a: assert property ($changed(q_r.level) |-> $past(q_r.cnt) == CNT_W'(PER - 1))
		else $error("level changed before filter period");
	short_pulse_drop_a: assert property ((q_r.s2 != q_r.s3) |=> $stable(q_r.level))
		else $error("unstable input moved the level");
	count_restart_a: assert property ((q_r.s3 == q_r.level) |=> q_r.cnt == '0)
		else $error("filter counter did not restart");
	cover_accept_c: cover property ($rose(q_r.level));
endmodule
`default_nettype wire

// *** ext_src.sv ***
// external isolated control source that drives the three control pins
`timescale 1ns/10ps
`default_nettype none
module ext_src (
	input wire logic i_clk,
	output wire logic o_ext_clk,
	output wire logic o_ext_start,
	output wire logic o_ext_stop
);
	logic [2:0] pins_r = 3'h0;
	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// pins idle low between pulses, as the filters expect
	assign o_ext_clk = pins_r[0];
	assign o_ext_start = pins_r[1];
	assign o_ext_stop = pins_r[2];
	// high for len clocks then low as long; caller sizes len for latency
	task automatic pulse(input int sel, input int len);
		pins_r[sel] <= 1'b1;
		repeat (len) @(posedge i_clk);
		pins_r[sel] <= 1'b0;
		repeat (len) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the sampling trigger and filter block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int FILT = 8;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_clk;
	logic ext_start;
	logic ext_stop;
	logic jmp_diff = 1'b0;
	logic jmp_cur = 1'b0;
	logic adc_valid = 1'b0;
	logic [11:0] adc_data = 12'h000;
	logic hold;
	logic adc_start;
	logic irq;
	logic [3:0] chan;
	logic [1:0] range;
	logic [31:0] rv;
	logic er;
	int num_errors = 0;
	int checks_done = 0;
	// 50 MHz clock
	always #10 i_clk = ~i_clk;
	sampling_trigger_filter #(.FILT_CYCLES(FILT), .ADDR_W(4)) sampling_trigger_filter_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_paddr(paddr), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_clk),
		.i_ext_start(ext_start), .i_ext_stop(ext_stop), .i_jmp_diff(jmp_diff),
		.i_jmp_current(jmp_cur), .o_hold(hold), .o_adc_start(adc_start), .o_chan(chan),
		.o_range(range), .i_adc_valid(adc_valid), .i_adc_data(adc_data), .o_irq(irq));
	ext_src ext_src_inst (.i_clk(i_clk), .o_ext_clk(ext_clk), .o_ext_start(ext_start),
		.o_ext_stop(ext_stop));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk(32'h1, 32'h0, "apb answer missing");
			end_of_test();
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv & m, e, "read value");
	endtask
	// bounded wait for a converter start pulse, n counts edges
	task automatic wait_start(output int n);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (adc_start !== 1'b1 && n < 200);
		if (n >= 200) begin
			chk(32'h1, 32'h0, "no converter start");
			end_of_test();
		end
	endtask
	// answer every conversion of one scan, channel 0 already started
	task automatic scan(input int last);
		int n;
		for (int ch = 0; ch <= last; ch++) begin
			if (ch > 0) begin
				wait_start(n);
			end
			chk({28'h0, chan}, ch, "channel order");
			adc_valid <= 1'b1;
			adc_data <= 12'h100 + 12'(ch);
			@(posedge i_clk);
			adc_valid <= 1'b0;
		end
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(stf_pkg::OFF_STATUS, 32'h3ff, 32'h009);
		rd(stf_pkg::OFF_INT_STAT, 32'hf, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped error");
		chk(rv, 32'h0, "unmapped data");
		$display("test reset done");
	endtask
	task automatic t_filter();
		int n;
		apb(1'b1, stf_pkg::OFF_CTRL, 32'h0c);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h1);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h2);
		rd(stf_pkg::OFF_STATUS, 32'h7, 32'h4);
		ext_src_inst.pulse(0, FILT - 1);
		chk({31'h0, hold}, 32'h0, "glitch passed");
		rd(stf_pkg::OFF_STATUS, 32'h380, 32'h0);
		repeat (2 * FILT) @(posedge i_clk);
		rd(stf_pkg::OFF_LEVEL, 32'hff, 32'h0);
		fork
			ext_src_inst.pulse(0, 3 * FILT);
		join_none
		wait_start(n);
		chk({31'h0, hold}, 32'h1, "hold with start");
		chk(n >= FILT + 3 && n <= FILT + 6, 32'h1, "filter latency");
		scan(15);
		repeat (6 * FILT) @(posedge i_clk);
		rd(stf_pkg::OFF_LEVEL, 32'hff, 32'h10);
		rd(stf_pkg::OFF_STATUS, 32'h18, 32'h10);
		$display("test filter done");
	endtask
	task automatic t_irq();
		rd(stf_pkg::OFF_INT_STAT, 32'h9, 32'h9);
		chk({31'h0, irq}, 32'h0, "irq while masked");
		apb(1'b1, stf_pkg::OFF_INT_EN, 32'h8);
		chk({31'h0, irq}, 32'h1, "irq enabled");
		apb(1'b1, stf_pkg::OFF_INT_CLR, 32'hf);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd(stf_pkg::OFF_INT_STAT, 32'hf, 32'h0);
		apb(1'b1, stf_pkg::OFF_INT_EN, 32'h0);
		$display("test irq done");
	endtask
	task automatic t_drain();
		for (int i = 0; i < 16; i++) begin
			rd(stf_pkg::OFF_DATA, 32'hfff, 32'h100 + i);
		end
		rd(stf_pkg::OFF_STATUS, 32'h18, 32'h08);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h4);
		rd(stf_pkg::OFF_STATUS, 32'h7, 32'h1);
		$display("test drain done");
	endtask
	task automatic t_ext();
		int n;
		jmp_diff <= 1'b1;
		jmp_cur <= 1'b1;
		apb(1'b1, stf_pkg::OFF_CTRL, 32'h8a);
		chk({30'h0, range}, 32'h2, "range output");
		apb(1'b1, stf_pkg::OFF_CMD, 32'h1);
		rd(stf_pkg::OFF_STATUS, 32'h67, 32'h62);
		ext_src_inst.pulse(1, 3 * FILT);
		rd(stf_pkg::OFF_STATUS, 32'h7, 32'h4);
		fork
			ext_src_inst.pulse(0, 3 * FILT);
		join_none
		wait_start(n);
		scan(7);
		repeat (6 * FILT) @(posedge i_clk);
		rd(stf_pkg::OFF_COUNT, 32'hff, 32'h8);
		ext_src_inst.pulse(2, 3 * FILT);
		rd(stf_pkg::OFF_STATUS, 32'h7, 32'h1);
		$display("test external done");
	endtask
	// compare start, count stop, ring overwrite of the oldest words
	task automatic t_ring();
		int n;
		apb(1'b1, stf_pkg::OFF_CMD, 32'h8);
		apb(1'b1, stf_pkg::OFF_CTRL, 32'h11);
		apb(1'b1, stf_pkg::OFF_CMP, 32'h105);
		apb(1'b1, stf_pkg::OFF_STOP_CNT, 32'h13);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h1);
		for (int k = 0; k < 3; k++) begin
			fork
				ext_src_inst.pulse(0, 3 * FILT);
			join_none
			wait_start(n);
			scan(7);
			repeat (6 * FILT) @(posedge i_clk);
		end
		rd(stf_pkg::OFF_STATUS, 32'h1f, 32'h11);
		rd(stf_pkg::OFF_COUNT, 32'hff, 32'h13);
		rd(stf_pkg::OFF_DATA, 32'hfff, 32'h100);
		$display("test ring done");
	endtask
	// software start, compare stop on a sample below the threshold
	task automatic t_cmp_stop();
		int n;
		apb(1'b1, stf_pkg::OFF_CMD, 32'h8);
		apb(1'b1, stf_pkg::OFF_CTRL, 32'h24);
		apb(1'b1, stf_pkg::OFF_CMP, 32'h103);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h1);
		apb(1'b1, stf_pkg::OFF_CMD, 32'h2);
		fork
			ext_src_inst.pulse(0, 3 * FILT);
		join_none
		wait_start(n);
		scan(7);
		repeat (6 * FILT) @(posedge i_clk);
		rd(stf_pkg::OFF_STATUS, 32'h7, 32'h1);
		rd(stf_pkg::OFF_LEVEL, 32'hff, 32'h1);
		$display("test compare stop done");
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_filter();
		t_irq();
		t_drain();
		t_ext();
		t_ring();
		t_cmp_stop();
		end_of_test();
	end
endmodule
`default_nettype wire
